// File: design/irq_bits.sv
/*
  Sticky event flags with write-one-to-clear, a mask of the same layout and
  one registered level interrupt. Assumes write strobes last one cycle.
*/
`timescale 1ns/100ps
module irq_bits #(
  parameter int N = 2
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [N-1:0] set_i,
  input wire logic clr_wr_i,
  input wire logic mask_wr_i,
  input wire logic [N-1:0] wdata_i,
  output logic [N-1:0] status_o,
  output logic [N-1:0] mask_o,
  output logic irq_o
);

  logic [N-1:0] status_next;

  // Set wins over a clear in the same cycle
  always_comb begin
    status_next = (status_o & ~(clr_wr_i ? wdata_i : '0)) | set_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      status_o <= '0;
    end else begin
      status_o <= status_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      mask_o <= '0;
    end else if (mask_wr_i) begin
      mask_o <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_o & mask_o);
    end
  end

endmodule

// File: design/watchdog_timer_reset.sv
/*
  Watchdog timer with AHB-Lite register slave, write-once options,
  service-by-write, reset request and interrupt on timeout.
  Assumes a single-cycle 1 ms slow oscillator tick synchronous to ref_clk_i,
  a debug-active level, and that wdog_reset_o is routed to the system reset.
*/
`timescale 1ns/100ps

// How it works
// - Counter runs only while enable bit set
// - Write to status address clears counter
// - Overflow without service requests system reset
// - Clock select: 0 slow oscillator, 1 bus
// - Period field sets power-of-two overflow count
// - Comes up enabled with default fields
// - Options register takes first write after reset or timeout only
// - Counting suspended while debug mode active
// - Timeout sets watchdog reset source bit
module watchdog_timer_reset
  import wdog_pkg::*;
#(
  parameter int SLOW_EXP = wdog_pkg::SLOW_BASE_EXP,
  parameter int BUS_EXP = wdog_pkg::BUS_BASE_EXP
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic slow_tick_i,
  input wire logic bdm_active_i,
  output logic wdog_reset_o,
  output logic irq_o
);
  import wdog_pkg::*;

  logic opt_en_reg;
  logic opt_clksel_reg;
  logic [2:0] opt_period_reg;
  logic opt_locked_reg;
  logic rst_src_wdog_reg;
  wd_state_e wd_state_reg;
  wd_state_e wd_state_next;
  logic dp_write_reg;
  logic [7:0] dp_addr_reg;
  logic ap_valid;
  logic wr_opts;
  logic wr_service;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic opt_reject;
  logic step;
  logic expire;
  logic [2:0] period_eff;
  logic [EXP_W-1:0] limit_exp;
  logic [CNT_W:0] count;
  logic [IRQ_N-1:0] irq_set;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_mask;
  logic [31:0] rd_next;

  // Bus decode: address phase captured, write applied in data phase
  always_comb begin
    ap_valid = hsel_i && htrans_i[1] && hready_i;
    wr_opts = dp_write_reg && (dp_addr_reg == OFS_OPTIONS);
    wr_service = dp_write_reg && (dp_addr_reg == OFS_RST_STATUS);
    wr_irq_status = dp_write_reg && (dp_addr_reg == OFS_IRQ_STATUS);
    wr_irq_mask = dp_write_reg && (dp_addr_reg == OFS_IRQ_MASK);
    opt_reject = wr_opts && opt_locked_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
    end else begin
      dp_write_reg <= ap_valid && hwrite_i;
      dp_addr_reg <= haddr_i[7:0];
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (haddr_i[7:0])
      OFS_OPTIONS: begin
        rd_next[OPT_EN_BIT] = opt_en_reg;
        rd_next[OPT_CLKSEL_BIT] = opt_clksel_reg;
        rd_next[OPT_PERIOD_LSB +: OPT_PERIOD_W] = opt_period_reg;
        rd_next[OPT_LOCK_BIT] = opt_locked_reg;
      end
      OFS_RST_STATUS: rd_next[RST_SRC_WDOG_BIT] = rst_src_wdog_reg;
      OFS_IRQ_STATUS: rd_next[IRQ_N-1:0] = irq_status;
      OFS_IRQ_MASK: rd_next[IRQ_N-1:0] = irq_mask;
      OFS_COUNT: rd_next[CNT_W:0] = count;
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (ap_valid && !hwrite_i) begin
      hrdata_o <= rd_next;
    end
  end

  // Write-once options; a timeout restores defaults and unlocks
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || expire) begin
      opt_en_reg <= OPT_EN_RST;
      opt_clksel_reg <= OPT_CLKSEL_RST;
      opt_period_reg <= OPT_PERIOD_RST;
      opt_locked_reg <= 1'b0;
    end else if (wr_opts && !opt_locked_reg) begin
      opt_en_reg <= hwdata_i[OPT_EN_BIT];
      opt_clksel_reg <= hwdata_i[OPT_CLKSEL_BIT];
      opt_period_reg <= hwdata_i[OPT_PERIOD_LSB +: OPT_PERIOD_W];
      opt_locked_reg <= 1'b1;
    end
  end

  // Watchdog run state
  always_comb begin
    if (!opt_en_reg) begin
      wd_state_next = WD_OFF;
    end else if (bdm_active_i) begin
      wd_state_next = WD_HALT;
    end else begin
      wd_state_next = WD_RUN;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wd_state_reg <= WD_RUN;
    end else begin
      wd_state_reg <= wd_state_next;
    end
  end

  // Counting clock and overflow exponent
  always_comb begin
    period_eff = (opt_period_reg > PERIOD_CAP) ? PERIOD_CAP : opt_period_reg;
    limit_exp = EXP_W'((opt_clksel_reg ? BUS_EXP : SLOW_EXP) + int'(period_eff));
    // Next state, so that enable and debug act without a cycle of lag
    unique case (wd_state_next)
      WD_RUN: step = opt_clksel_reg ? 1'b1 : slow_tick_i;
      WD_OFF: step = 1'b0;
      WD_HALT: step = 1'b0;
      default: step = 1'b0;
    endcase
  end

  wdog_counter u_counter (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .clear_i(wr_service || (wd_state_reg == WD_OFF)),
    .step_i(step),
    .limit_exp_i(limit_exp),
    .count_o(count),
    .expire_o(expire)
  );

  // Reset request and source record
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wdog_reset_o <= 1'b0;
    end else begin
      wdog_reset_o <= expire;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rst_src_wdog_reg <= 1'b0;
    end else if (expire) begin
      rst_src_wdog_reg <= 1'b1;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_TIMEOUT_BIT] = expire;
    irq_set[IRQ_LOCKED_BIT] = opt_reject;
  end

  irq_bits #(
    .N(IRQ_N)
  ) u_irq (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .set_i(irq_set),
    .clr_wr_i(wr_irq_status),
    .mask_wr_i(wr_irq_mask),
    .wdata_i(hwdata_i[IRQ_N-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  run_when_enabled_a: assert property (!opt_en_reg |-> !expire)
    else $error("watchdog expired while disabled");

  service_clears_a: assert property (wr_service |=> count == '0)
    else $error("service write did not clear counter");

  timeout_reset_a: assert property (expire |=> wdog_reset_o ##1 !wdog_reset_o)
    else $error("timeout did not give one reset pulse");

  slow_clock_gate_a: assert property (
    (wd_state_reg == WD_RUN) && !opt_clksel_reg && !slow_tick_i && !wr_service
      |=> $stable(count))
    else $error("counter moved without slow tick");

  period_count_a: assert property (
    expire |-> ({11'h000, count} + 32'h0000_0001) == (32'h0000_0001
      << ((opt_clksel_reg ? BUS_EXP : SLOW_EXP)
      + ((opt_period_reg == 3'h7) ? 6 : int'(opt_period_reg)))))
    else $error("overflow at wrong count");

  reset_defaults_a: assert property (disable iff (1'b0)
    !nrst_i |=> opt_en_reg && !opt_clksel_reg && (opt_period_reg == OPT_PERIOD_RST)
      && !opt_locked_reg && (count == '0))
    else $error("defaults wrong after reset");

  write_once_a: assert property (
    opt_locked_reg && wr_opts && !expire
      |=> $stable(opt_en_reg) && $stable(opt_clksel_reg) && $stable(opt_period_reg))
    else $error("locked options changed");

  debug_hold_a: assert property (
    bdm_active_i ##1 (bdm_active_i && !wr_service) |=> $stable(count) && !wdog_reset_o)
    else $error("counter ran in debug mode");

  source_bit_a: assert property (expire |=> rst_src_wdog_reg)
    else $error("watchdog source bit not set");

  // Further checks on enable, write-once, reset request and bus answer
  disabled_clear_a: assert property (
    (wd_state_reg == WD_OFF) |=> count == '0)
    else $error("counter not held at zero while disabled");

  bus_clock_step_a: assert property (
    opt_en_reg && !bdm_active_i && opt_clksel_reg && (wd_state_reg != WD_OFF)
      && !wr_service && !expire |=> count == $past(count) + {{CNT_W{1'b0}}, 1'b1})
    else $error("counter missed a bus clock step");

  status_kept_a: assert property (
    wr_service && !expire |=> $stable(rst_src_wdog_reg))
    else $error("service write changed reset status");

  pulse_cause_a: assert property (
    wdog_reset_o |-> $past(expire))
    else $error("reset request without timeout");

  timeout_defaults_a: assert property (
    expire |=> opt_en_reg && !opt_clksel_reg && (opt_period_reg == OPT_PERIOD_RST)
      && !opt_locked_reg)
    else $error("options not restored by timeout");

  first_write_locks_a: assert property (
    wr_opts && !opt_locked_reg && !expire |=> opt_locked_reg)
    else $error("first options write did not lock");

  reject_flag_a: assert property (
    opt_reject |=> irq_status[IRQ_LOCKED_BIT])
    else $error("rejected options write not flagged");

  debug_no_timeout_a: assert property (
    bdm_active_i |-> !expire)
    else $error("timeout while debug mode active");

  irq_level_a: assert property (
    irq_o == ($past(nrst_i) && $past(|(irq_status & irq_mask))))
    else $error("interrupt output does not follow status and mask");

  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready and OKAY");

  timeout_seen_c: cover property (expire);
  disabled_seen_c: cover property (wd_state_reg == WD_OFF);
  service_seen_c: cover property (wr_service && count != '0);
  locked_write_c: cover property (opt_reject);
  debug_pause_c: cover property ((wd_state_reg == WD_HALT) ##1 (wd_state_reg == WD_RUN));

endmodule

// File: design/wdog_counter.sv
/*
  Watchdog up-counter with a power-of-two overflow point. Assumes step_i
  is a one-cycle qualifier and limit_exp_i stays inside the counter width.
*/
`timescale 1ns/100ps
module wdog_counter (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic [wdog_pkg::EXP_W-1:0] limit_exp_i,
  output logic [wdog_pkg::CNT_W:0] count_o,
  output logic expire_o
);
  import wdog_pkg::*;

  logic [CNT_W:0] last_val;

  always_comb begin
    last_val = (({{CNT_W{1'b0}}, 1'b1}) << limit_exp_i) - {{CNT_W{1'b0}}, 1'b1};
    expire_o = step_i && !clear_i && (count_o == last_val);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      count_o <= '0;
    end else if (clear_i || expire_o) begin
      count_o <= '0;
    end else if (step_i) begin
      count_o <= count_o + {{CNT_W{1'b0}}, 1'b1};
    end
  end

endmodule

// File: design/wdog_pkg.sv
/*
  Shared constants for the watchdog block: register byte offsets, field
  positions, reset values, count exponents and the watchdog state codes.
  Assumes a 32-bit AHB-Lite register bus and a 10 MHz system clock.
*/
package wdog_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_OPTIONS = 8'h00;
  localparam logic [7:0] OFS_RST_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;

  // system_options_reg fields
  localparam int OPT_EN_BIT = 0;
  localparam int OPT_CLKSEL_BIT = 1;
  localparam int OPT_PERIOD_LSB = 2;
  localparam int OPT_PERIOD_W = 3;
  localparam int OPT_LOCK_BIT = 7;

  // system_options_reg values after reset
  localparam logic OPT_EN_RST = 1'b1;
  localparam logic OPT_CLKSEL_RST = 1'b0;
  localparam logic [2:0] OPT_PERIOD_RST = 3'h7;

  // reset_status_reg field
  localparam int RST_SRC_WDOG_BIT = 5;

  // Interrupt status and mask layout
  localparam int IRQ_N = 2;
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_LOCKED_BIT = 1;

  // Counter width and overflow exponents
  localparam int CNT_W = 20;
  localparam int EXP_W = 5;
  localparam int SLOW_BASE_EXP = 5;
  localparam int BUS_BASE_EXP = 13;
  localparam logic [2:0] PERIOD_CAP = 3'h6;

  // Clock rate and the slow oscillator period
  localparam int CLK_HZ = 10_000_000;
  localparam int SLOW_TICK_US = 1000;
  localparam int SLOW_TICK_CYC = SLOW_TICK_US * (CLK_HZ / 1_000_000);

  typedef enum logic [2:0] {
    WD_OFF = 3'b001,
    WD_RUN = 3'b010,
    WD_HALT = 3'b100
  } wd_state_e;

endpackage

// File: tb/tb_watchdog_timer_reset.sv
/*
  Self-checking bench for the watchdog block: register reads, write-once
  options, service writes, timeout timing in both clock modes, debug hold.
  Assumes the design files are compiled first and hready is looped back.
*/
`timescale 1ns/100ps
module tb_watchdog_timer_reset;
  import wdog_pkg::*;
  logic ref_clk_i;
  logic nrst_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic slow_tick_i = 1'b0;
  logic bdm_active_i = 1'b0;
  logic [31:0] hrdata_o;
  logic hreadyout_o, hresp_o, wdog_reset_o, irq_o;
  logic rd_phase = 1'b0;
  logic tick_en = 1'b0;
  logic use_tick = 1'b0;
  int steps = 0;
  int seed = 37753;
  int miscompares = 0;
  int n_checks = 0;
  logic [31:0] rq[$];
  int pq[$];

  watchdog_timer_reset #(.SLOW_EXP(2), .BUS_EXP(3)) watchdog_timer_reset_inst (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .slow_tick_i(slow_tick_i), .bdm_active_i(bdm_active_i),
    .wdog_reset_o(wdog_reset_o), .irq_o(irq_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk32(input string name, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk_near(input string name, input int e, input int g);
    n_checks++;
    if (g < e - 2 || g > e + 2) begin
      miscompares++;
      $display("ERROR %s expected %0d seen %0d", name, e, g);
    end
  endtask

  // Results are compared as they appear, against the oldest note
  always @(posedge ref_clk_i) begin
    if (rd_phase && hreadyout_o === 1'b1) chk32("hrdata_o", rq.pop_front(), hrdata_o);
    if (nrst_i && !bdm_active_i && (!use_tick || slow_tick_i)) steps <= steps + 1;
    if (wdog_reset_o === 1'b1) begin
      if (pq.size() == 0) chk_near("wdog_reset_o unexpected", -10, steps);
      else chk_near("wdog_reset_o step", pq.pop_front(), steps);
    end
  end

  always @(posedge ref_clk_i) slow_tick_i <= tick_en && ($random(seed) & 1);

  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d,
                     input logic [31:0] e);
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    htrans_i <= 2'h2;
    hsel_i <= 1'b1;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rd_phase <= !wr;
    if (!wr) rq.push_back(e);
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
    rd_phase <= 1'b0;
    chk32("hresp_o", 32'h0, {31'h0, hresp_o});
  endtask

  task automatic do_reset;
    nrst_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
  endtask

  task automatic wait_pulse;
    for (int i = 0; i < 2000 && pq.size() != 0; i++) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    chk32("wdog_reset_o pending", 32'h0, pq.size());
    pq.delete();
  endtask

  function automatic logic [31:0] opt(input logic en, input logic sel, input int p);
    return {27'h0, p[2:0], sel, en};
  endfunction

  function automatic int span(input int base, input int p);
    return 1 << (base + (p > 6 ? 6 : p));
  endfunction

  logic [7:0] ra[6] = '{OFS_OPTIONS, OFS_RST_STATUS, OFS_IRQ_STATUS, OFS_IRQ_MASK,
                        OFS_COUNT, 8'h20};
  logic [31:0] re[6] = '{32'h1D, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  initial begin
    int start;
    do_reset();
    for (int i = 0; i < 6; i++) bus(ra[i], 1'b0, 32'h0, re[i]);
    bus(OFS_OPTIONS, 1'b1, opt(1, 1, 7), 32'h0);
    bus(OFS_OPTIONS, 1'b0, 32'h0, opt(1, 1, 7) | 32'h80);
    bus(OFS_OPTIONS, 1'b1, 32'h0, 32'h0);
    bus(OFS_OPTIONS, 1'b0, 32'h0, opt(1, 1, 7) | 32'h80);
    bus(OFS_IRQ_STATUS, 1'b0, 32'h0, 32'h2);
    bus(OFS_IRQ_MASK, 1'b1, 32'h3, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    chk32("irq_o", 32'h1, {31'h0, irq_o});
    bus(OFS_IRQ_STATUS, 1'b1, 32'h2, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    chk32("irq_o", 32'h0, {31'h0, irq_o});
    // Services spaced just short of the 512-step overflow
    for (int i = 0; i < 8; i++) begin
      bus(OFS_RST_STATUS, 1'b1, $random(seed), 32'h0);
      start = steps;
      if (i == 7) pq.push_back(start + 512);
      repeat (450) @(posedge ref_clk_i);
    end
    bus(OFS_RST_STATUS, 1'b0, 32'h0, 32'h0);
    wait_pulse();
    bus(OFS_OPTIONS, 1'b0, 32'h0, 32'h1D);
    bus(OFS_RST_STATUS, 1'b1, 32'hFFFF_FFFF, 32'h0);
    bus(OFS_RST_STATUS, 1'b0, 32'h0, 32'h20);
    bus(OFS_IRQ_STATUS, 1'b0, 32'h0, 32'h1);
    chk32("irq_o", 32'h1, {31'h0, irq_o});
    bus(OFS_IRQ_STATUS, 1'b1, 32'h1, 32'h0);
    bus(OFS_OPTIONS, 1'b1, opt(0, 1, 0), 32'h0);
    repeat (300) @(posedge ref_clk_i);
    bus(OFS_COUNT, 1'b0, 32'h0, 32'h0);
    bus(OFS_OPTIONS, 1'b0, 32'h0, opt(0, 1, 0) | 32'h80);
    for (int p = 0; p < 8; p++) begin
      do_reset();
      bus(OFS_RST_STATUS, 1'b0, 32'h0, 32'h0);
      bus(OFS_OPTIONS, 1'b1, opt(1, 1, p), 32'h0);
      pq.push_back(steps + span(3, p));
      wait_pulse();
    end
    do_reset();
    bus(OFS_OPTIONS, 1'b1, opt(1, 1, 1), 32'h0);
    pq.push_back(steps + 16);
    bdm_active_i <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    bdm_active_i <= 1'b0;
    wait_pulse();
    use_tick = 1'b1;
    for (int p = 0; p < 8; p++) begin
      do_reset();
      bus(OFS_OPTIONS, 1'b1, opt(1, 0, p), 32'h0);
      pq.push_back(steps + span(2, p));
      tick_en <= 1'b1;
      wait_pulse();
      tick_en <= 1'b0;
    end
    report_and_stop();
  end

  initial begin
    #3_000_000;
    miscompares++;
    report_and_stop();
  end
endmodule
